/* File: design/alud_disch_current.sv */
`timescale 1ns/1ns
module alud_disch_current
  import alud_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic [ALUD_VW-1:0] line_level,
  input wire logic [ALUD_VW-1:0] end_level,
  input wire logic [ALUD_VW-1:0] knee_level,
  output logic [7:0] current_code
);

  logic [7:0] code_nxt;
  logic [ALUD_VW+7:0] num;
  logic [ALUD_VW-1:0] span;
  logic [ALUD_VW-1:0] above;

  // ----------------------------------------------------------------------
  // Linear current taper
  // ----------------------------------------------------------------------
  // Full current above the knee, linear down to the minimum at the end level.
  // Division is costly but runs at a leisurely rate; a table would be smaller.
  always_comb begin
    span = knee_level - end_level;
    above = (line_level > end_level) ? line_level - end_level : '0;
    num = '0;
    if (!enable) begin
      code_nxt = 8'h00;
    end else if (line_level >= knee_level || span == '0) begin
      code_nxt = DISCH_FULL_CODE;
    end else begin
      num = (ALUD_VW+8)'(above) * (ALUD_VW+8)'(DISCH_FULL_CODE - DISCH_MIN_CODE);
      code_nxt = DISCH_MIN_CODE + 8'(num / (ALUD_VW+8)'(span));
    end
  end

  // Output code is registered, as a data output.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      current_code <= 8'h00;
    end else begin
      current_code <= code_nxt;
    end
  end

endmodule

/* File: design/alud_pkg.sv */
package alud_pkg;

  // ----------------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------------
  localparam int ALUD_VW = 10;
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int SAMPLE_PERIOD_US = 1000;
  localparam int SAMPLE_CYCLES = (CLK_FREQ_HZ / 1_000_000) * SAMPLE_PERIOD_US;
  localparam int NEG_WINDOW_MS = 10;
  localparam int NEG_WINDOW_SAMPLES = NEG_WINDOW_MS * 1000 / SAMPLE_PERIOD_US;
  localparam int RESTART_SLOPE_MS = 2;
  localparam int RESTART_SAMPLES = RESTART_SLOPE_MS * 1000 / SAMPLE_PERIOD_US;
  localparam int UNPLUG_TIMEOUT_MS = 32;
  localparam int UNPLUG_TIMEOUT_SAMPLES = UNPLUG_TIMEOUT_MS * 1000 / SAMPLE_PERIOD_US;

  // ----------------------------------------------------------------------
  // Analog levels in sense codes, and discharge current codes
  // ----------------------------------------------------------------------
  localparam logic [ALUD_VW-1:0] SLOPE_OFFSET_RST = 10'h008;
  localparam logic [ALUD_VW-1:0] DISCH_END_LEVEL_RST = 10'h010;
  localparam logic [ALUD_VW-1:0] DISCH_KNEE_LEVEL_RST = 10'h050;
  localparam logic [7:0] DISCH_FULL_CODE = 8'hFF;
  localparam logic [7:0] DISCH_MIN_CODE = 8'h10;

  // ----------------------------------------------------------------------
  // Discharge sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ALUD_IDLE = 2'b00,
    ALUD_DISCH = 2'b01,
    ALUD_WAIT_SLOPE = 2'b10
  } alud_state_t;

endpackage

/* File: design/alud_sample_tick.sv */
`timescale 1ns/1ns
module alud_sample_tick
  import alud_pkg::*;
#(
  parameter int PERIOD = SAMPLE_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic tick
);

  logic [$clog2(PERIOD+1)-1:0] cnt_r;
  logic [$clog2(PERIOD+1)-1:0] cnt_nxt;
  logic tick_nxt;

  // ----------------------------------------------------------------------
  // Sample period divider
  // ----------------------------------------------------------------------
  // Next count wraps after one sampling period.
  always_comb begin
    tick_nxt = (cnt_r == ($clog2(PERIOD+1))'(PERIOD - 1));
    cnt_nxt = tick_nxt ? '0 : cnt_r + 1'b1;
  end

  // Registered tick so the strobe is glitch free.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end

endmodule

/* File: design/alud_top.sv */
`timescale 1ns/1ns
module alud_top
  import alud_pkg::*;
#(
  parameter int SAMPLE_PERIOD = SAMPLE_CYCLES,
  parameter int TIMEOUT_SAMPLES = UNPLUG_TIMEOUT_SAMPLES,
  parameter int NEG_SAMPLES = NEG_WINDOW_SAMPLES,
  parameter int RESTART_SLOPE = RESTART_SAMPLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ALUD_VW-1:0] line_sense,
  input wire logic [ALUD_VW-1:0] slope_offset,
  input wire logic [ALUD_VW-1:0] discharge_end_level,
  input wire logic [ALUD_VW-1:0] discharge_knee_level,
  input wire logic stop_event,
  output logic slope_comparator_out,
  output logic dc_detect,
  output logic discharge_en,
  output logic [7:0] discharge_current,
  output logic switching_stop,
  output logic startup_block,
  output logic restart_ok
);

  localparam int TW = $clog2(TIMEOUT_SAMPLES + 2);
  localparam int NW = $clog2(NEG_SAMPLES + 2);
  localparam int RW = $clog2(RESTART_SLOPE + 2);

  logic tick;
  logic [ALUD_VW-1:0] held_r, held_nxt;
  logic cmp_r, cmp_nxt;
  logic [TW-1:0] det_r, det_nxt;
  logic [NW-1:0] neg_r, neg_nxt;
  logic dc_r, dc_nxt;
  alud_state_t st_r, st_nxt;
  logic [RW-1:0] pos_r, pos_nxt;
  logic rok_r, rok_nxt;
  logic [ALUD_VW:0] thr_up;
  logic [ALUD_VW:0] thr_dn;
  logic pos_seen;
  logic neg_seen;
  logic cmp_edge;
  logic line_low;

  // ----------------------------------------------------------------------
  // Sample clock
  // ----------------------------------------------------------------------
  // One strobe per sampling period gates all detector state.
  alud_sample_tick #(.PERIOD(SAMPLE_PERIOD)) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // Slope comparator and detection timer
  // ----------------------------------------------------------------------
  // The held sample plus offset sets the up threshold; a mirrored offset below
  // it catches falling slopes. Widened sums avoid overflow at full scale.
  always_comb begin
    thr_up = {1'b0, held_r} + {1'b0, slope_offset};
    thr_dn = ({1'b0, held_r} > {1'b0, slope_offset}) ? {1'b0, held_r} - {1'b0, slope_offset} : '0;
    pos_seen = ({1'b0, line_sense} > thr_up);
    neg_seen = ({1'b0, line_sense} < thr_dn) && (neg_r != '0);
    held_nxt = held_r;
    cmp_nxt = cmp_r;
    det_nxt = det_r;
    neg_nxt = neg_r;
    dc_nxt = dc_r;
    cmp_edge = 1'b0;
    if (tick) begin
      held_nxt = line_sense;
      if (pos_seen) begin
        cmp_nxt = 1'b1;
      end else if (neg_seen) begin
        cmp_nxt = 1'b0;
      end else begin
        cmp_nxt = 1'b0;
      end
      cmp_edge = pos_seen || neg_seen || (cmp_nxt != cmp_r);
      if (pos_seen) begin
        neg_nxt = NW'(NEG_SAMPLES);
      end else if (neg_r != '0) begin
        neg_nxt = neg_r - 1'b1;
      end
      if (cmp_edge) begin
        det_nxt = '0;
        dc_nxt = 1'b0;
      end else if (det_r >= TW'(TIMEOUT_SAMPLES - 1)) begin
        det_nxt = det_r;
        dc_nxt = 1'b1;
      end else begin
        det_nxt = det_r + 1'b1;
      end
    end
  end

  // Detector state registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held_r <= '0;
      cmp_r <= 1'b0;
      det_r <= '0;
      neg_r <= '0;
      dc_r <= 1'b0;
    end else begin
      held_r <= held_nxt;
      cmp_r <= cmp_nxt;
      det_r <= det_nxt;
      neg_r <= neg_nxt;
      dc_r <= dc_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Discharge sequencer and restart qualifier
  // ----------------------------------------------------------------------
  // No mode input gates this machine, so it stays armed in standby and fault.
  always_comb begin
    line_low = (line_sense < discharge_end_level);
    st_nxt = st_r;
    pos_nxt = pos_r;
    rok_nxt = rok_r;
    case (st_r)
      ALUD_IDLE: begin
        if (dc_r) begin
          st_nxt = ALUD_DISCH;
        end else if (stop_event) begin
          st_nxt = ALUD_WAIT_SLOPE;
          pos_nxt = '0;
          rok_nxt = 1'b0;
        end
      end
      ALUD_DISCH: begin
        rok_nxt = 1'b0;
        pos_nxt = '0;
        if (line_low) begin
          st_nxt = ALUD_WAIT_SLOPE;
        end
      end
      ALUD_WAIT_SLOPE: begin
        // Only a fresh timeout re-arms the discharge here. The flag left from the last
        // discharge is stale until a tick that sees a slope edge clears it, and would trap a rising line.
        if (tick && dc_nxt && !dc_r && !line_low) begin
          st_nxt = ALUD_DISCH;
        end else if (tick) begin
          if (pos_seen) begin
            if (pos_r >= RW'(RESTART_SLOPE - 1)) begin
              st_nxt = ALUD_IDLE;
              rok_nxt = 1'b1;
            end else begin
              pos_nxt = pos_r + 1'b1;
            end
          end else begin
            pos_nxt = '0;
          end
        end
      end
      default: begin
        st_nxt = ALUD_IDLE;
      end
    endcase
  end

  // Sequencer registers; restart is permitted at power-on.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ALUD_IDLE;
      pos_r <= '0;
      rok_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      pos_r <= pos_nxt;
      rok_r <= rok_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Discharge current and outputs
  // ----------------------------------------------------------------------
  alud_disch_current u_cur (
    .clk(clk),
    .arst_n(arst_n),
    .enable(st_r == ALUD_DISCH),
    .line_level(line_sense),
    .end_level(discharge_end_level),
    .knee_level(discharge_knee_level),
    .current_code(discharge_current)
  );

  // Outputs come straight from state flops.
  assign slope_comparator_out = cmp_r;
  assign dc_detect = dc_r;
  assign discharge_en = (st_r == ALUD_DISCH);
  assign switching_stop = (st_r == ALUD_DISCH);
  assign startup_block = (st_r == ALUD_DISCH) || !rok_r;
  assign restart_ok = rok_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_disch;
    st_r == ALUD_DISCH;
  endsequence

  AST_DISCH_ON_DC: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == ALUD_IDLE && dc_r) |=> s_disch) else $error("discharge not started on dc detect");
  AST_DISCH_END: assert property (@(posedge clk) disable iff (!arst_n)
    (s_disch and line_low) |=> !discharge_en) else $error("discharge did not end");
  AST_SW_STOP: assert property (@(posedge clk) disable iff (!arst_n)
    discharge_en |-> switching_stop) else $error("switching during discharge");
  AST_START_BLOCK: assert property (@(posedge clk) disable iff (!arst_n)
    discharge_en |-> startup_block) else $error("startup not blocked");
  AST_EDGE_RESET: assert property (@(posedge clk) disable iff (!arst_n)
    (tick && cmp_edge) |=> (det_r == '0)) else $error("timer not restarted on edge");
  AST_POS_FLAG: assert property (@(posedge clk) disable iff (!arst_n)
    (tick && pos_seen) |=> (slope_comparator_out && neg_r == NW'(NEG_SAMPLES))) else $error("positive slope lost");
  AST_NEG_WINDOW: assert property (@(posedge clk) disable iff (!arst_n)
    (tick && neg_r == '0 && !pos_seen && !cmp_r && det_r < TW'(TIMEOUT_SAMPLES - 1))
    |=> (det_r == $past(det_r) + 1'b1)) else $error("negative edge outside window");
  AST_DC_FLAG: assert property (@(posedge clk) disable iff (!arst_n)
    (tick && !cmp_edge && det_r >= TW'(TIMEOUT_SAMPLES - 1)) |=> dc_detect) else $error("dc detect missing");
  AST_CUR_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    !discharge_en [*2] |-> (discharge_current == 8'h00)) else $error("current without discharge");
  AST_RESTART: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(restart_ok) |-> $past(st_r) == ALUD_WAIT_SLOPE) else $error("restart without slope");

endmodule

/* File: dv/alud_line_model.sv */
`timescale 1ns/1ns
module alud_line_model
  import alud_pkg::*;
#(
  parameter int PERIOD = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic signed [10:0] delta,
  input wire logic [7:0] drain,
  output logic [ALUD_VW-1:0] line_sense
);
  // --------------------------------------------------------------------
  // Line voltage image
  // --------------------------------------------------------------------
  // The line moves by delta once a period; an active discharge current drains
  // the filter capacitor a little further, slower than the slope offset.
  int cnt;
  int v;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      v <= 100;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (cnt == 0) begin
        v <= v + int'(delta) - ((drain != 8'h00) ? 6 : 0) < 0 ? 0 : v + int'(delta) - ((drain != 8'h00) ? 6 : 0);
      end
    end
  end
  assign line_sense = (v > 1023) ? 10'h3FF : v[ALUD_VW-1:0];
endmodule

/* File: dv/alud_top_tb_top.sv */
`timescale 1ns/1ns
module alud_top_tb_top
  import alud_pkg::*;
;
  // --------------------------------------------------------------------
  // Clock, reset and wiring
  // --------------------------------------------------------------------
  localparam int SP = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic stop_event = 1'b0;
  logic signed [10:0] delta = 11'sd0;
  logic [ALUD_VW-1:0] line_sense;
  logic cmp, dc_detect, discharge_en, switching_stop, startup_block, restart_ok;
  logic [7:0] discharge_current;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int i;
  always #25 clk = ~clk;
  alud_line_model #(.PERIOD(SP)) alud_line_model_i (.clk(clk), .arst_n(arst_n), .delta(delta),
    .drain(discharge_current), .line_sense(line_sense));
  alud_top #(.SAMPLE_PERIOD(SP), .TIMEOUT_SAMPLES(4)) alud_top_i (.clk(clk), .arst_n(arst_n),
    .line_sense(line_sense), .slope_offset(SLOPE_OFFSET_RST), .discharge_end_level(DISCH_END_LEVEL_RST),
    .discharge_knee_level(DISCH_KNEE_LEVEL_RST), .stop_event(stop_event), .slope_comparator_out(cmp),
    .dc_detect(dc_detect), .discharge_en(discharge_en), .discharge_current(discharge_current),
    .switching_stop(switching_stop), .startup_block(startup_block), .restart_ok(restart_ok));

  // --------------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------------
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n * SP) @(negedge clk);
  endtask
  // The whole sequence needs about 1500 to 2400 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  // Current must taper but never vanish between the knee and the end level.
  function automatic logic taper_ok(input logic [7:0] c);
    return (c < DISCH_FULL_CODE) && (c >= DISCH_MIN_CODE);
  endfunction

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    i = $urandom(59947);
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    check("restart_ok", restart_ok, 1);
    check("dc_detect", dc_detect, 0);
    check("discharge_en", discharge_en, 0);
    check("startup_block", startup_block, 0);
    // A steady rising line keeps the comparator high and the timer reset.
    delta = 11'sd20 + 11'($urandom_range(0, 15));
    for (i = 0; i < 12; i++) begin
      ticks(1);
      check("dc_detect ac", dc_detect, 0);
    end
    // A stop in idle withholds restart until two positive samples arrive.
    stop_event = 1'b1;
    @(negedge clk);
    stop_event = 1'b0;
    repeat (2) @(negedge clk);
    check("restart_ok stop", restart_ok, 0);
    check("startup_block stop", startup_block, 1);
    ticks(4);
    check("restart_ok slope", restart_ok, 1);
    // Falling slope: accepted only shortly after the last positive edge.
    // A slow fall keeps the line well above the knee when the timeout strikes.
    delta = -11'sd12;
    ticks(7);
    check("dc_detect fall", dc_detect, 0);
    for (i = 0; i < 12 * SP && dc_detect !== 1'b1; i++) @(negedge clk);
    check("dc_detect late", dc_detect, 1);
    delta = 11'sd0;
    repeat (3) @(negedge clk);
    check("discharge_en", discharge_en, 1);
    check("switching_stop", switching_stop, 1);
    check("startup_block", startup_block, 1);
    check("current full", discharge_current, DISCH_FULL_CODE);
    for (i = 0; i < 80 * SP && line_sense >= DISCH_KNEE_LEVEL_RST - 10'h008; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    check("current taper", taper_ok(discharge_current), 1);
    check("discharge hold", discharge_en, 1);
    for (i = 0; i < 20 * SP && discharge_en !== 1'b0; i++) @(negedge clk);
    check("end reached", line_sense < DISCH_END_LEVEL_RST, 1);
    repeat (2) @(negedge clk);
    check("current off", discharge_current, 0);
    check("switching_stop off", switching_stop, 0);
    check("restart_ok wait", restart_ok, 0);
    check("startup_block wait", startup_block, 1);
    delta = 11'sd30;
    ticks(4);
    check("restart_ok resume", restart_ok, 1);
    check("startup_block resume", startup_block, 0);
    finish_test();
  end
endmodule
